// file: rtl/sdsp_pkg.sv
package sdsp_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int NS_PER_US = 1000;
    localparam int NS_PER_MS = 1000000;
    // resolution in pulses per revolution
    localparam logic [13:0] RES_BASE_FULL = 14'h03E8;
    localparam logic [13:0] RES_BASE_HALF = 14'h01F4;
    localparam logic [13:0] RES_MULT_TEN = 14'h000A;
    // operating current in percent of the driver maximum, per dial position
    localparam logic [6:0] CUR_PCT [16] = '{7'h06, 7'h0D, 7'h13, 7'h19, 7'h1F, 7'h26, 7'h2C,
        7'h32, 7'h38, 7'h3F, 7'h45, 7'h4B, 7'h51, 7'h58, 7'h5E, 7'h64};
    // smoothing time constants in microseconds, position 0 means no filter
    localparam logic [19:0] FILT_US [16] = '{20'h0_0000, 20'h0_0078, 20'h0_00A0, 20'h0_010E,
        20'h0_019A, 20'h0_0334, 20'h0_04B0, 20'h0_0640, 20'h0_0A8C, 20'h0_1004, 20'h0_2008,
        20'h0_2EE0, 20'h0_3E80, 20'h0_6978, 20'h0_A028, 20'h1_4050};
    localparam logic [7:0] HEAT_LIMIT_C = 8'h55;
    localparam logic [15:0] SPEED_LIMIT_RPM = 16'h1388;
    localparam int OVERLOAD_MS = 5000;
    localparam int BLINK_MS = 200;
    localparam int PAUSE_MS = 1200;
    // fault numbers equal their blink counts; 9 blinks continuously
    localparam int FLT_HEAT = 1;
    localparam int FLT_LOAD = 2;
    localparam int FLT_VOLT = 3;
    localparam int FLT_FOLLOW = 4;
    localparam int FLT_CURR = 5;
    localparam int FLT_SPEED = 6;
    localparam int FLT_PARAM = 7;
    localparam int FLT_SENSOR = 8;
    localparam int FLT_SYS = 9;
    localparam logic [9:0] FLT_CLEARABLE = 10'h15E;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_CONT = 4'h9;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_DEVIATION = 8'h0C;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_CUTOFF_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic half_base;
        logic fixed_ten;
        logic dual_mode;
        logic [3:0] cur_dial;
        logic [3:0] filt_dial;
    } sdsp_cfg_t;

    typedef enum logic [3:0] {
        BLK_IDLE = 4'b0001,
        BLK_ON = 4'b0010,
        BLK_OFF = 4'b0100,
        BLK_PAUSE = 4'b1000
    } sdsp_blink_t;
endpackage

// file: rtl/sdsp_blink.sv
`timescale 1ns/100ps
module sdsp_blink import sdsp_pkg::*; #(
    parameter int ON_CYCLES = 2000000,
    parameter int PAUSE_CYCLES = 12000000
) (
    input wire logic clk_in, // system clock
    input wire logic rstn_in, // async reset, active low
    input wire logic [3:0] code_in, // blink count, 9 continuous, 0 none
    output logic led_out // fault lamp
);
    sdsp_blink_t st_q;
    logic [31:0] tmr_q;
    logic [3:0] cnt_q;
    logic [31:0] lim;

    assign lim = (st_q == BLK_PAUSE) ? PAUSE_CYCLES - 1 : ON_CYCLES - 1;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= BLK_IDLE;
            tmr_q <= '0;
            cnt_q <= '0;
        end else if (code_in == CODE_NONE) begin
            st_q <= BLK_IDLE;
            tmr_q <= '0;
            cnt_q <= '0;
        end else begin
            tmr_q <= (st_q == BLK_IDLE || tmr_q == lim) ? '0 : tmr_q + 32'h0000_0001;
            unique case (st_q)
                BLK_IDLE: begin
                    st_q <= BLK_ON;
                    cnt_q <= 4'h1;
                end
                BLK_ON: if (tmr_q == lim) st_q <= BLK_OFF;
                BLK_OFF: if (tmr_q == lim) begin
                    // continuous code never pauses
                    if (code_in != CODE_CONT && cnt_q >= code_in) begin
                        st_q <= BLK_PAUSE;
                    end else begin
                        st_q <= BLK_ON;
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                BLK_PAUSE: if (tmr_q == lim) begin
                    st_q <= BLK_ON;
                    cnt_q <= 4'h1;
                end
            endcase
        end
    end

    assign led_out = (st_q == BLK_ON);

    AST_PAUSE_DARK: assert property (@(posedge clk_in) disable iff (!rstn_in)
        st_q == BLK_OFF && tmr_q == lim && code_in != CODE_CONT && cnt_q < code_in
        |=> st_q == BLK_ON)
        else $error("pause entered before the flash group was complete");
endmodule

// file: rtl/sdsp_smooth.sv
`timescale 1ns/100ps
module sdsp_smooth import sdsp_pkg::*; (
    input wire logic clk_in, // system clock
    input wire logic rstn_in, // async reset, active low
    input wire logic flush_in, // drop any pending steps
    input wire logic cw_in, // accepted clockwise command step
    input wire logic ccw_in, // accepted counter-clockwise command step
    input wire logic [19:0] tau_in, // time constant in cycles, 0 no filter
    output logic step_out, // smoothed step pulse
    output logic dir_cw_out // sense of step_out, 1 clockwise
);
    // first-order lag: step rate equals pending error over tau
    logic signed [15:0] err_q;
    logic [35:0] acc_q;
    logic [15:0] mag;
    logic fire;

    assign mag = err_q[15] ? 16'(-err_q) : err_q;
    assign fire = (err_q != 16'sh0000) && (tau_in == '0 || acc_q + 36'(mag) >= 36'(tau_in));

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            err_q <= '0;
            acc_q <= '0;
            step_out <= 1'b0;
            dir_cw_out <= 1'b1;
        end else if (flush_in) begin
            err_q <= '0;
            acc_q <= '0;
            step_out <= 1'b0;
        end else begin
            step_out <= fire;
            if (fire) dir_cw_out <= !err_q[15];
            err_q <= err_q + 16'(cw_in) - 16'(ccw_in) - (fire ? (err_q[15] ? -16'sh0001 :
                16'sh0001) : 16'sh0000);
            if (err_q == 16'sh0000) acc_q <= '0;
            else acc_q <= fire ? acc_q + 36'(mag) - 36'(tau_in) : acc_q + 36'(mag);
        end
    end

    AST_NO_FILTER: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !flush_in && tau_in == '0 && err_q != 16'sh0000 |=> step_out)
        else $error("unfiltered step was delayed");
endmodule

// file: rtl/sdsp_top.sv
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module sdsp_top import sdsp_pkg::*; #(
    parameter int CYCLE_NS = CLK_PERIOD_NS,
    parameter int OVERLOAD_CYCLES = OVERLOAD_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int BLINK_CYCLES = BLINK_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int PAUSE_CYCLES = PAUSE_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter logic [15:0] FOLLOW_LIMIT = 16'h0100
) (
    input wire logic SYS_CLK_IN, // 10 MHz system clock
    input wire logic RSTN_IN, // power-on reset, active low
    input wire logic [7:0] AWADDR_IN, // write address
    input wire logic AWVALID_IN, // write address valid
    output logic AWREADY_OUT, // write address ready
    input wire logic [31:0] WDATA_IN, // write data
    input wire logic [3:0] WSTRB_IN, // write byte strobes
    input wire logic WVALID_IN, // write data valid
    output logic WREADY_OUT, // write data ready
    output logic [1:0] BRESP_OUT, // write response
    output logic BVALID_OUT, // write response valid
    input wire logic BREADY_IN, // write response ready
    input wire logic [7:0] ARADDR_IN, // read address
    input wire logic ARVALID_IN, // read address valid
    output logic ARREADY_OUT, // read address ready
    output logic [31:0] RDATA_OUT, // read data
    output logic [1:0] RRESP_OUT, // read response
    output logic RVALID_OUT, // read data valid
    input wire logic RREADY_IN, // read data ready
    input wire logic CLOCKWISE_STEP_PULSE_IN, // cw pulse, dual mode
    input wire logic COUNTERCLOCKWISE_STEP_PULSE_IN, // ccw pulse, dual mode
    input wire logic STEP_PULSE_INPUT_IN, // step pulse, pulse-plus-sense mode
    input wire logic SENSE_CW_IN, // direction level, 1 clockwise
    input wire logic TIMES_TEN_IN, // tenfold resolution request
    input wire logic FAULT_CLEAR_INPUT_IN, // alarm clear, rising edge acts
    input wire logic HALF_BASE_SW_IN, // 1 selects 500 base
    input wire logic FIXED_TEN_SW_IN, // 1 selects x10 multiplier switch
    input wire logic DUAL_PULSE_MODE_SW_IN, // 1 dual-pulse, 0 pulse-plus-sense
    input wire logic [3:0] CURRENT_DIAL_IN, // operating current dial
    input wire logic [3:0] SMOOTHING_TIME_DIAL_IN, // speed filter dial
    input wire logic [7:0] HEATSINK_TEMP_C_IN, // heat-sink temperature
    input wire logic TORQUE_EXCESS_IN, // load above maximum torque
    input wire logic OVERVOLTAGE_IN, // inverter supply above limit
    input wire logic OVERCURRENT_IN, // power element over current
    input wire logic [15:0] SHAFT_RPM_IN, // measured shaft speed
    input wire logic PARAM_CORRUPT_IN, // stored motor data bad
    input wire logic CABLE_PRESENT_IN, // motor cable detected
    input wire logic SYSTEM_FAULT_IN, // internal failure
    input wire logic MOTOR_STEP_IN, // one-cycle pulse per actual motor step
    input wire logic MOTOR_DIR_CW_IN, // sense of MOTOR_STEP_IN
    output logic ALARM_OK_OUT, // high while no trip latched
    output logic FAULT_LED_OUT, // blink code lamp
    output logic CURRENT_ENABLE_OUT, // motor current allowed
    output logic [6:0] CURRENT_SETPOINT_OUT, // percent of driver maximum
    output logic [13:0] RESOLUTION_OUT, // pulses per revolution
    output logic STEP_OUT, // smoothed step to the power stage
    output logic DIR_CW_OUT // sense of STEP_OUT
);
    sdsp_cfg_t cfg_q;
    logic init_q;
    logic [9:0] fault_q;
    logic [9:0] event_v;
    logic tripped;
    logic clear_req;
    logic [3:0] code_d;
    logic step_prev_q, cw_prev_q, ccw_prev_q, clr_prev_q;
    logic cw_acc, ccw_acc;
    logic [31:0] load_cnt_q;
    logic signed [15:0] dev_q;
    logic [15:0] dev_mag;
    logic [19:0] tau;
    logic cut_q, sw_clear_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [31:0] rd_d;
    logic rd_ok;

    // switches are caught by the first clocked edge after reset release
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            init_q <= 1'b0;
            cfg_q <= '0;
        end else if (!init_q) begin
            init_q <= 1'b1;
            cfg_q <= '{HALF_BASE_SW_IN, FIXED_TEN_SW_IN, DUAL_PULSE_MODE_SW_IN,
                CURRENT_DIAL_IN, SMOOTHING_TIME_DIAL_IN};
        end
    end

    // fixed x10 switch overrides the input, as the switch disables it
    assign RESOLUTION_OUT = 14'((cfg_q.half_base ? RES_BASE_HALF : RES_BASE_FULL) *
        ((cfg_q.fixed_ten || TIMES_TEN_IN) ? RES_MULT_TEN : 14'h0001));

    // command decode; rising edges only, simultaneous dual pulses cancel
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            step_prev_q <= 1'b0;
            cw_prev_q <= 1'b0;
            ccw_prev_q <= 1'b0;
            clr_prev_q <= 1'b0;
        end else begin
            step_prev_q <= STEP_PULSE_INPUT_IN;
            cw_prev_q <= CLOCKWISE_STEP_PULSE_IN;
            ccw_prev_q <= COUNTERCLOCKWISE_STEP_PULSE_IN;
            clr_prev_q <= FAULT_CLEAR_INPUT_IN;
        end
    end

    always_comb begin
        cw_acc = 1'b0;
        ccw_acc = 1'b0;
        if (init_q && !tripped) begin
            if (cfg_q.dual_mode) begin
                cw_acc = CLOCKWISE_STEP_PULSE_IN && !cw_prev_q;
                ccw_acc = COUNTERCLOCKWISE_STEP_PULSE_IN && !ccw_prev_q;
                if (cw_acc && ccw_acc) begin
                    cw_acc = 1'b0;
                    ccw_acc = 1'b0;
                end
            end else begin
                cw_acc = STEP_PULSE_INPUT_IN && !step_prev_q && SENSE_CW_IN;
                ccw_acc = STEP_PULSE_INPUT_IN && !step_prev_q && !SENSE_CW_IN;
            end
        end
    end

    assign tau = 20'(FILT_US[cfg_q.filt_dial] * (NS_PER_US / CYCLE_NS));

    sdsp_smooth u_smooth (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .flush_in(tripped || cut_q),
        .cw_in(cw_acc),
        .ccw_in(ccw_acc),
        .tau_in(tau),
        .step_out(STEP_OUT),
        .dir_cw_out(DIR_CW_OUT)
    );

    // deviation between drive output and actual motion; cutoff clears it
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            dev_q <= '0;
        end else if (cut_q || clear_req) begin
            dev_q <= '0;
        end else begin
            dev_q <= dev_q + (STEP_OUT ? (DIR_CW_OUT ? 16'sh0001 : -16'sh0001) : 16'sh0000)
                - (MOTOR_STEP_IN ? (MOTOR_DIR_CW_IN ? 16'sh0001 : -16'sh0001) : 16'sh0000);
        end
    end
    assign dev_mag = dev_q[15] ? 16'(-dev_q) : dev_q;

    // excess torque must persist without a gap
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            load_cnt_q <= '0;
        end else if (!TORQUE_EXCESS_IN) begin
            load_cnt_q <= '0;
        end else if (load_cnt_q < OVERLOAD_CYCLES) begin
            load_cnt_q <= load_cnt_q + 32'h0000_0001;
        end
    end

    always_comb begin
        event_v = '0;
        event_v[FLT_HEAT] = HEATSINK_TEMP_C_IN >= HEAT_LIMIT_C;
        event_v[FLT_LOAD] = load_cnt_q >= OVERLOAD_CYCLES;
        event_v[FLT_VOLT] = OVERVOLTAGE_IN;
        event_v[FLT_FOLLOW] = dev_mag > FOLLOW_LIMIT;
        event_v[FLT_CURR] = OVERCURRENT_IN;
        event_v[FLT_SPEED] = SHAFT_RPM_IN > SPEED_LIMIT_RPM;
        event_v[FLT_PARAM] = PARAM_CORRUPT_IN;
        event_v[FLT_SENSOR] = !init_q && !CABLE_PRESENT_IN;
        event_v[FLT_SYS] = SYSTEM_FAULT_IN;
    end

    assign clear_req = (FAULT_CLEAR_INPUT_IN && !clr_prev_q) || sw_clear_q;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            fault_q <= '0;
        end else begin
            fault_q <= (fault_q & ~(clear_req ? FLT_CLEARABLE : 10'h000)) | event_v;
        end
    end
    assign tripped = |fault_q;

    always_comb begin
        code_d = CODE_NONE;
        for (int i = FLT_SENSOR; i >= FLT_HEAT; i--) begin
            if (fault_q[i]) code_d = 4'(i);
        end
        if (fault_q[FLT_SYS]) code_d = CODE_CONT;
    end

    sdsp_blink #(
        .ON_CYCLES(BLINK_CYCLES),
        .PAUSE_CYCLES(PAUSE_CYCLES)
    ) u_blink (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .code_in(code_d),
        .led_out(FAULT_LED_OUT)
    );

    assign ALARM_OK_OUT = init_q && !tripped;
    assign CURRENT_ENABLE_OUT = init_q && !tripped && !cut_q;
    assign CURRENT_SETPOINT_OUT = CURRENT_ENABLE_OUT ? CUR_PCT[cfg_q.cur_dial] : '0;

    // AXI4-Lite slave: address and data are held until both are present
    assign AWREADY_OUT = !aw_hold_q && !BVALID_OUT;
    assign WREADY_OUT = !w_hold_q && !BVALID_OUT;
    assign do_write = aw_hold_q && w_hold_q && !BVALID_OUT;

    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= RESP_OKAY;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT) begin
                w_hold_q <= 1'b1;
                wdata_q <= WDATA_IN;
                wstrb_q <= WSTRB_IN;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                BVALID_OUT <= 1'b1;
                BRESP_OUT <= (awaddr_q[7:2] <= REG_DEVIATION[7:2]) ? RESP_OKAY : RESP_SLVERR;
            end else if (BVALID_OUT && BREADY_IN) begin
                BVALID_OUT <= 1'b0;
            end
        end
    end

    // control register: clear is a self-clearing strobe, cutoff a level
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cut_q <= 1'b0;
            sw_clear_q <= 1'b0;
        end else begin
            sw_clear_q <= do_write && awaddr_q == REG_CTRL && wstrb_q[0] &&
                wdata_q[CTRL_CLEAR_BIT];
            if (do_write && awaddr_q == REG_CTRL && wstrb_q[0]) cut_q <= wdata_q[CTRL_CUTOFF_BIT];
        end
    end

    always_comb begin
        rd_d = '0;
        rd_ok = 1'b1;
        unique case (ARADDR_IN)
            REG_CTRL: rd_d[CTRL_CUTOFF_BIT] = cut_q;
            REG_STATUS: rd_d = {18'h0_0000, code_d, fault_q[9:1], ALARM_OK_OUT};
            REG_CONFIG: rd_d = {cfg_q.cur_dial, cfg_q.filt_dial, 6'h00, RESOLUTION_OUT, 1'b0,
                cfg_q.half_base, cfg_q.fixed_ten, cfg_q.dual_mode};
            REG_DEVIATION: rd_d = 32'(unsigned'(dev_q));
            default: rd_ok = 1'b0;
        endcase
    end

    assign ARREADY_OUT = !RVALID_OUT;

    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= '0;
            RRESP_OUT <= RESP_OKAY;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RDATA_OUT <= rd_d;
            RRESP_OUT <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT <= 1'b0;
        end
    end

    AST_TRIP_CUTS: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        tripped |-> !ALARM_OK_OUT && !CURRENT_ENABLE_OUT && CURRENT_SETPOINT_OUT == '0)
        else $error("trip did not drop alarm and current");
    AST_OVERSPEED: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        SHAFT_RPM_IN > SPEED_LIMIT_RPM |=> fault_q[FLT_SPEED] && !ALARM_OK_OUT)
        else $error("overspeed did not trip");
    AST_OVERHEAT: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        HEATSINK_TEMP_C_IN >= HEAT_LIMIT_C |=> fault_q[FLT_HEAT])
        else $error("overheat did not trip");
    AST_NO_CLEAR: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        fault_q[FLT_CURR] || fault_q[FLT_PARAM] || fault_q[FLT_SYS] |=> tripped)
        else $error("permanent fault was cleared");
    AST_CLEAR_WORKS: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        clear_req && (fault_q & ~FLT_CLEARABLE) == '0 && event_v == '0 |=> ALARM_OK_OUT)
        else $error("clearable fault survived a clear");
    AST_CFG_HELD: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        init_q |=> $stable(cfg_q))
        else $error("configuration changed after power-up");
    AST_STEP_BLOCK: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        tripped |=> !STEP_OUT)
        else $error("step passed while tripped");
    AST_OVERLOAD_TIME: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        load_cnt_q < OVERLOAD_CYCLES - 1 && !fault_q[FLT_LOAD] |=> !fault_q[FLT_LOAD])
        else $error("overload tripped early");
    AST_RESOLUTION: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        init_q && !cfg_q.fixed_ten && !TIMES_TEN_IN |-> RESOLUTION_OUT ==
        (cfg_q.half_base ? RES_BASE_HALF : RES_BASE_FULL))
        else $error("plain resolution wrong");
    AST_SENSE_MODE: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        !cfg_q.dual_mode && (cw_acc || ccw_acc) |-> cw_acc == SENSE_CW_IN)
        else $error("direction level not obeyed");
endmodule

// file: tb/sdsp_ctrl_model.sv
`timescale 1ns/100ps
module sdsp_ctrl_model (
    input wire logic clk_in, // system clock
    input wire logic rstn_in, // reset, active low
    input wire logic go_in, // issue one step pulse
    input wire logic [1:0] kind_in, // 0 cw, 1 ccw, 2 step with sense
    output logic cw_out, // clockwise pulse
    output logic ccw_out, // counter-clockwise pulse
    output logic pls_out // step pulse
);
    logic [2:0] cnt_q;
    logic [1:0] kind_q;
    // two cycles high, at least three low: the driver always sees a low sample between pulses
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= 3'h0;
            kind_q <= 2'h0;
        end else if (go_in && cnt_q == 3'h0) begin
            cnt_q <= 3'h4;
            kind_q <= kind_in;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    assign cw_out = cnt_q > 3'h2 && kind_q == 2'h0;
    assign ccw_out = cnt_q > 3'h2 && kind_q == 2'h1;
    assign pls_out = cnt_q > 3'h2 && kind_q == 2'h2;
endmodule

// file: tb/tb_sdsp_top.sv
`timescale 1ns/100ps
module tb_sdsp_top import sdsp_pkg::*;;
    logic SYS_CLK_IN = 0, RSTN_IN = 0, AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0;
    logic ARVALID_IN = 0, RREADY_IN = 0, SENSE_CW_IN = 1, TIMES_TEN_IN = 0, go = 0;
    logic FAULT_CLEAR_INPUT_IN = 0, HALF_BASE_SW_IN = 0, FIXED_TEN_SW_IN = 0;
    logic DUAL_PULSE_MODE_SW_IN = 1, TORQUE_EXCESS_IN = 0, OVERVOLTAGE_IN = 0;
    logic OVERCURRENT_IN = 0, PARAM_CORRUPT_IN = 0, CABLE_PRESENT_IN = 1;
    logic SYSTEM_FAULT_IN = 0, MOTOR_STEP_IN = 0, MOTOR_DIR_CW_IN = 1;
    logic [7:0] AWADDR_IN = 0, ARADDR_IN = 0, HEATSINK_TEMP_C_IN = 8'h19;
    logic [31:0] WDATA_IN = 0;
    logic [3:0] WSTRB_IN = 4'hF, CURRENT_DIAL_IN = 0, SMOOTHING_TIME_DIAL_IN = 0;
    logic [15:0] SHAFT_RPM_IN = 0;
    logic [1:0] kind = 0, BRESP_OUT, RRESP_OUT;
    logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT, ALARM_OK_OUT;
    logic FAULT_LED_OUT, CURRENT_ENABLE_OUT, STEP_OUT, DIR_CW_OUT;
    logic CLOCKWISE_STEP_PULSE_IN, COUNTERCLOCKWISE_STEP_PULSE_IN, STEP_PULSE_INPUT_IN;
    logic [31:0] RDATA_OUT;
    logic [6:0] CURRENT_SETPOINT_OUT;
    logic [13:0] RESOLUTION_OUT;
    logic dq[$];
    logic [33:0] rq[$];
    int fails = 0, checks_done = 0;
    logic led_q = 0;
    int blinks = 0;
    sdsp_top #(.OVERLOAD_CYCLES(20), .BLINK_CYCLES(4), .PAUSE_CYCLES(12)) dut_u (
        .SYS_CLK_IN, .RSTN_IN, .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT, .WDATA_IN, .WSTRB_IN,
        .WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN,
        .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN, .CLOCKWISE_STEP_PULSE_IN,
        .COUNTERCLOCKWISE_STEP_PULSE_IN, .STEP_PULSE_INPUT_IN, .SENSE_CW_IN, .TIMES_TEN_IN,
        .FAULT_CLEAR_INPUT_IN, .HALF_BASE_SW_IN, .FIXED_TEN_SW_IN, .DUAL_PULSE_MODE_SW_IN,
        .CURRENT_DIAL_IN, .SMOOTHING_TIME_DIAL_IN, .HEATSINK_TEMP_C_IN, .TORQUE_EXCESS_IN,
        .OVERVOLTAGE_IN, .OVERCURRENT_IN, .SHAFT_RPM_IN, .PARAM_CORRUPT_IN, .CABLE_PRESENT_IN,
        .SYSTEM_FAULT_IN, .MOTOR_STEP_IN, .MOTOR_DIR_CW_IN, .ALARM_OK_OUT, .FAULT_LED_OUT,
        .CURRENT_ENABLE_OUT, .CURRENT_SETPOINT_OUT, .RESOLUTION_OUT, .STEP_OUT, .DIR_CW_OUT);
    sdsp_ctrl_model ctl_u (.clk_in(SYS_CLK_IN), .rstn_in(RSTN_IN), .go_in(go),
        .kind_in(kind), .cw_out(CLOCKWISE_STEP_PULSE_IN),
        .ccw_out(COUNTERCLOCKWISE_STEP_PULSE_IN), .pls_out(STEP_PULSE_INPUT_IN));
    always #50 SYS_CLK_IN = ~SYS_CLK_IN;
    // the motor follows every output step, so no follow error builds up
    always @(posedge SYS_CLK_IN) begin
        MOTOR_STEP_IN <= STEP_OUT;
        MOTOR_DIR_CW_IN <= DIR_CW_OUT;
    end
    task chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // outputs stand one cycle, so each result is seen at exactly one falling edge
    always @(negedge SYS_CLK_IN) begin
        if (STEP_OUT === 1'b1)
            chk({33'h0, DIR_CW_OUT}, dq.size() ? dq.pop_front() : 34'h2);
        if (RVALID_OUT === 1'b1 && RREADY_IN) chk({RRESP_OUT, RDATA_OUT}, rq.pop_front());
        if (BVALID_OUT === 1'b1 && BREADY_IN) chk({BRESP_OUT, 32'h0}, rq.pop_front());
    end
    // lamp sampled mid-cycle, away from the edge that moves it
    always @(negedge SYS_CLK_IN) begin
        led_q <= FAULT_LED_OUT;
        if (FAULT_LED_OUT && !led_q) blinks <= blinks + 1;
    end
    task cyc(input int n);
        repeat (n) @(posedge SYS_CLK_IN);
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        rq.push_back({RESP_OKAY, 32'h0000_0000});
        AWADDR_IN <= a;
        WDATA_IN <= d;
        AWVALID_IN <= 1;
        WVALID_IN <= 1;
        do begin
            @(negedge SYS_CLK_IN);
            ta = AWVALID_IN && AWREADY_OUT;
            tw = WVALID_IN && WREADY_OUT;
            cyc(1);
            if (ta) AWVALID_IN <= 0;
            if (tw) WVALID_IN <= 0;
        end while ((AWVALID_IN && !ta) || (WVALID_IN && !tw));
        BREADY_IN <= 1;
        do begin
            @(negedge SYS_CLK_IN);
            ta = BVALID_OUT;
            cyc(1);
        end while (!ta);
        BREADY_IN <= 0;
    endtask
    task axi_rd(input logic [7:0] a, input logic [33:0] e);
        logic t;
        rq.push_back(e);
        ARADDR_IN <= a;
        ARVALID_IN <= 1;
        RREADY_IN <= 1;
        do begin
            @(negedge SYS_CLK_IN);
            t = ARREADY_OUT;
            cyc(1);
        end while (!t);
        ARVALID_IN <= 0;
        do begin
            @(negedge SYS_CLK_IN);
            t = RVALID_OUT;
            cyc(1);
        end while (!t);
        RREADY_IN <= 0;
        cyc(1);
    endtask
    task step(input logic [1:0] k, input logic d, input logic e);
        if (e) dq.push_back(d);
        kind <= k;
        go <= 1;
        cyc(1);
        go <= 0;
        cyc(8);
    endtask
    task boot(input logic dual, input logic half);
        DUAL_PULSE_MODE_SW_IN <= dual;
        HALF_BASE_SW_IN <= half;
        RSTN_IN <= 0;
        cyc(6);
        RSTN_IN <= 1;
        cyc(3);
        DUAL_PULSE_MODE_SW_IN <= !dual;
    endtask
    task lv(input logic a, input logic [6:0] sp, input logic [13:0] res);
        @(negedge SYS_CLK_IN);
        chk(ALARM_OK_OUT, a);
        chk(CURRENT_ENABLE_OUT, a);
        chk(CURRENT_SETPOINT_OUT, sp);
        chk(RESOLUTION_OUT, res);
        cyc(1);
    endtask
    task test_done;
        $display("Checks %0d, errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        fails++;
        test_done;
    end
    initial begin
        logic [6:0] pct;
        int n;
        void'($urandom(15));
        CURRENT_DIAL_IN = 4'($urandom);
        pct = 7'((100 * (CURRENT_DIAL_IN + 1) + 8) / 16);
        boot(1, 0);
        lv(1, pct, 14'h03E8);
        TIMES_TEN_IN <= 1;
        lv(1, pct, 14'h2710);
        step(0, 1, 1);
        step(1, 0, 1);
        SHAFT_RPM_IN <= 16'h1389;
        cyc(1);
        SHAFT_RPM_IN <= 16'h1388;
        cyc(2);
        lv(0, 7'h00, 14'h2710);
        step(0, 1, 0);
        axi_rd(REG_STATUS, {RESP_OKAY, 32'h0000_1840});
        axi_rd(8'h10, {RESP_SLVERR, 32'h0000_0000});
        FAULT_CLEAR_INPUT_IN <= 1;
        cyc(1);
        FAULT_CLEAR_INPUT_IN <= 0;
        cyc(2);
        lv(1, pct, 14'h2710);
        OVERVOLTAGE_IN <= 1;
        cyc(1);
        OVERVOLTAGE_IN <= 0;
        cyc(2);
        axi_rd(REG_STATUS, {RESP_OKAY, 32'h0000_0C08});
        axi_wr(REG_CTRL, 32'h0000_0001);
        cyc(3);
        lv(1, pct, 14'h2710);
        OVERCURRENT_IN <= 1;
        cyc(1);
        OVERCURRENT_IN <= 0;
        FAULT_CLEAR_INPUT_IN <= 1;
        cyc(2);
        FAULT_CLEAR_INPUT_IN <= 0;
        cyc(2);
        lv(0, 7'h00, 14'h2710);
        n = blinks;
        cyc(52);
        chk(34'(blinks - n), 34'h5);
        FIXED_TEN_SW_IN <= 1;
        TIMES_TEN_IN <= 0;
        boot(0, 1);
        lv(1, pct, 14'h1388);
        SENSE_CW_IN <= 0;
        step(2, 0, 1);
        SENSE_CW_IN <= 1;
        step(2, 1, 1);
        TORQUE_EXCESS_IN <= 1;
        cyc(20);
        lv(1, pct, 14'h1388);
        lv(0, 7'h00, 14'h1388);
        axi_rd(REG_STATUS, {RESP_OKAY, 32'h0000_0804});
        chk(34'(dq.size() + rq.size()), 34'h0);
        test_done;
    end
endmodule
